//--- design/emb_mod_pkg.sv
// Constants shared by the embedded clock duty modulator.
// What this block does
// R01 - Hold a sixteen bit modulation step.
// R02 - Step counts distribution clock half periods.
// R03 - Two 28-bit spacing counts, four bytes each.
// R04 - Spacing counts output divider clock cycles.
// R05 - Two bit feedback sync edge offset.
// R06 - Offset applies only while modulation is on.
// R07 - Edge request gives exactly five events.
// R08 - Level request gives events while asserted.
// R09 - Single pulse select chooses event type.
// R10 - Polarity bit sets event shape.
// R11 - Modulator enable gates all events.
// R12 - Reserved bits read zero, writes ignored.
package emb_mod_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam int STEP_W = 16;
    localparam int SPACING_W = 28;
    localparam int SYNC_OFS_W = 2;
    localparam int SETTINGS_W = 4;
    localparam int NIBBLE_W = 4;
    localparam logic [ADDR_W-1:0] ADDR_STEP_LO = 16'h14c0;
    localparam logic [ADDR_W-1:0] ADDR_STEP_HI = 16'h14c1;
    localparam logic [ADDR_W-1:0] ADDR_SPACING_A0 = 16'h14c2;
    localparam logic [ADDR_W-1:0] ADDR_SPACING_A1 = 16'h14c3;
    localparam logic [ADDR_W-1:0] ADDR_SPACING_A2 = 16'h14c4;
    localparam logic [ADDR_W-1:0] ADDR_SPACING_A3 = 16'h14c5;
    localparam logic [ADDR_W-1:0] ADDR_SPACING_B0 = 16'h14c6;
    localparam logic [ADDR_W-1:0] ADDR_SPACING_B1 = 16'h14c7;
    localparam logic [ADDR_W-1:0] ADDR_SPACING_B2 = 16'h14c8;
    localparam logic [ADDR_W-1:0] ADDR_SPACING_B3 = 16'h14c9;
    localparam logic [ADDR_W-1:0] ADDR_SYNC_OFS = 16'h14ce;
    localparam logic [ADDR_W-1:0] ADDR_MOD_FIRST = 16'h14cf;
    localparam logic [DATA_W-1:0] RESET_BYTE = 8'h00;
    localparam int BIT_ENABLE = 0;
    localparam int BIT_POLARITY = 1;
    localparam int BIT_SINGLE = 2;
    localparam int BIT_BURST = 3;
    localparam logic [2:0] BURST_SHOTS = 3'h5;
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_COUNT = 2'b01,
        ST_FIRST = 2'b10,
        ST_SECOND = 2'b11
    } mod_state_t;
endpackage : emb_mod_pkg

//--- design/mod_channel.sv
// One output's modulation event generator, paced by the divider tick.
`timescale 1ns/100ps
module mod_channel #(
    parameter int SPACING_W = emb_mod_pkg::SPACING_W,
    parameter int STEP_W = emb_mod_pkg::STEP_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic enable,
    input wire logic polarity,
    input wire logic single_pulse,
    input wire logic burst_enable,
    input wire logic burst_mode_level,
    input wire logic burst_req,
    input wire logic div_tick,
    input wire logic [SPACING_W-1:0] spacing,
    input wire logic [STEP_W-1:0] step,
    output logic ev_active_q,
    output logic ev_high_q,
    output logic ev_start_q,
    output logic [STEP_W-1:0] ev_shift_q
);
    emb_mod_pkg::mod_state_t state_q, state_d;
    logic [SPACING_W-1:0] count_q, count_d, count_inc;
    logic [2:0] shots_q, shots_d;
    logic req_q, single_lat_q, single_lat_d, pol_lat_q, pol_lat_d;
    logic ev_active_d, ev_high_d, ev_start_d;
    logic [STEP_W-1:0] ev_shift_d;
    logic allowed, start;

    always_comb begin
        count_inc = count_q + SPACING_W'(1);
        // Burst gating: level mode follows the request, edge mode spends shots.
        if (!burst_enable) begin
            allowed = 1'b1;
        end else if (burst_mode_level) begin
            allowed = burst_req; // R08
        end else begin
            allowed = (shots_q != 3'h0); // R07
        end
        // A zero spacing behaves as one tick so the counter never stalls.
        start = (state_q == emb_mod_pkg::ST_COUNT) && div_tick && allowed
                && (count_inc >= spacing); // R04
        state_d = state_q;
        count_d = count_q;
        shots_d = shots_q;
        single_lat_d = single_lat_q;
        pol_lat_d = pol_lat_q;
        ev_shift_d = ev_shift_q;
        ev_start_d = 1'b0;
        if (burst_enable && !burst_mode_level && burst_req && !req_q) begin
            shots_d = emb_mod_pkg::BURST_SHOTS; // R07
        end else if (start && burst_enable && !burst_mode_level) begin
            shots_d = shots_q - 3'h1; // R07
        end
        if (!burst_enable || burst_mode_level) begin
            shots_d = 3'h0;
        end
        if (!enable) begin
            state_d = emb_mod_pkg::ST_IDLE; // R11
            count_d = '0;
        end else begin
            case (state_q)
                emb_mod_pkg::ST_IDLE: begin
                    state_d = emb_mod_pkg::ST_COUNT;
                end
                emb_mod_pkg::ST_COUNT: begin
                    if (start) begin
                        state_d = emb_mod_pkg::ST_FIRST;
                        count_d = '0;
                        single_lat_d = single_pulse; // R09
                        pol_lat_d = polarity; // R10
                        ev_shift_d = step; // R02
                        ev_start_d = 1'b1;
                    end else if (div_tick && count_inc < spacing) begin
                        count_d = count_inc; // R04
                    end
                end
                emb_mod_pkg::ST_FIRST: begin
                    if (div_tick) begin
                        state_d = single_lat_q ? emb_mod_pkg::ST_COUNT
                                               : emb_mod_pkg::ST_SECOND; // R09
                    end
                end
                emb_mod_pkg::ST_SECOND: begin
                    if (div_tick) begin
                        state_d = emb_mod_pkg::ST_COUNT;
                    end
                end
                default: begin
                    state_d = emb_mod_pkg::ST_IDLE;
                end
            endcase
        end
        ev_active_d = (state_d == emb_mod_pkg::ST_FIRST) || (state_d == emb_mod_pkg::ST_SECOND);
        // First phase takes the polarity level, the balancing phase its inverse.
        ev_high_d = ev_active_d && ((state_d == emb_mod_pkg::ST_FIRST) ? pol_lat_d
                                                                       : !pol_lat_d); // R10
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q <= emb_mod_pkg::ST_IDLE;
            count_q <= '0;
            shots_q <= 3'h0;
            req_q <= 1'b0;
            single_lat_q <= 1'b0;
            pol_lat_q <= 1'b0;
            ev_active_q <= 1'b0;
            ev_high_q <= 1'b0;
            ev_start_q <= 1'b0;
            ev_shift_q <= '0;
        end else begin
            state_q <= state_d;
            count_q <= count_d;
            shots_q <= shots_d;
            req_q <= burst_req;
            single_lat_q <= single_lat_d;
            pol_lat_q <= pol_lat_d;
            ev_active_q <= ev_active_d;
            ev_high_q <= ev_high_d;
            ev_start_q <= ev_start_d;
            ev_shift_q <= ev_shift_d;
        end
    end

    AST_OFF_QUIET: assert property (@(posedge clk) disable iff (rst) // R11
        !enable |=> !ev_active_q) else $error("Event active while disabled.");
    AST_FIRST_SHAPE: assert property (@(posedge clk) disable iff (rst) // R10
        $rose(ev_active_q) |-> ev_high_q == $past(polarity))
        else $error("First phase level does not follow polarity.");
    AST_SINGLE_ONE_PHASE: assert property (@(posedge clk) disable iff (rst) // R09
        state_q == emb_mod_pkg::ST_SECOND |-> !single_lat_q)
        else $error("Balancing phase seen in single pulse mode.");
    AST_BURST_LOAD: assert property (@(posedge clk) disable iff (rst) // R07
        (enable && burst_enable && !burst_mode_level && burst_req && !req_q)
        |=> shots_q == emb_mod_pkg::BURST_SHOTS) else $error("Burst did not load five.");
    AST_LEVEL_GATE: assert property (@(posedge clk) disable iff (rst) // R08
        (burst_enable && burst_mode_level && !burst_req && state_q == emb_mod_pkg::ST_COUNT)
        |=> state_q != emb_mod_pkg::ST_FIRST) else $error("Event without level request.");
    AST_SHIFT_STEP: assert property (@(posedge clk) disable iff (rst) // R02
        $rose(ev_active_q) |-> ev_shift_q == $past(step))
        else $error("Event shift does not match step.");
    AST_TICK_PACED: assert property (@(posedge clk) disable iff (rst) // R04
        (enable && !div_tick) |=> count_q == $past(count_q))
        else $error("Spacing counter moved without a divider tick.");
    COV_BALANCED: cover property (@(posedge clk) disable iff (rst)
        state_q == emb_mod_pkg::ST_FIRST ##1 state_q == emb_mod_pkg::ST_SECOND);
    COV_BURST_DONE: cover property (@(posedge clk) disable iff (rst)
        shots_q == 3'h1 ##1 shots_q == 3'h0);
endmodule : mod_channel

//--- design/emb_clock_modulator.sv
// Register file, sync edge offset and two modulation channels.
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/100ps
module emb_clock_modulator (
    input wire logic clk,
    input wire logic rst,
    input wire logic [emb_mod_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [emb_mod_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [emb_mod_pkg::DATA_W-1:0] reg_rdata,
    input wire logic first_div_tick,
    input wire logic second_div_tick,
    input wire logic burst_request,
    input wire logic burst_request_mode,
    input wire logic second_modulator_enable,
    input wire logic second_event_polarity,
    input wire logic second_single_pulse_select,
    input wire logic second_burst_enable,
    input wire logic fb_sync_base,
    output logic first_event_active,
    output logic first_event_high,
    output logic [emb_mod_pkg::STEP_W-1:0] first_event_shift,
    output logic second_event_active,
    output logic second_event_high,
    output logic [emb_mod_pkg::STEP_W-1:0] second_event_shift,
    output logic fb_sync
);
    localparam int SW = emb_mod_pkg::SPACING_W;
    localparam int DW = emb_mod_pkg::DATA_W;
    localparam int NW = emb_mod_pkg::NIBBLE_W;

    logic [emb_mod_pkg::STEP_W-1:0] step_q, step_d;
    logic [SW-1:0] spacing_a_q, spacing_a_d, spacing_b_q, spacing_b_d;
    logic [emb_mod_pkg::SYNC_OFS_W-1:0] sync_ofs_q, sync_ofs_d;
    logic [emb_mod_pkg::SETTINGS_W-1:0] mod_first_q, mod_first_d;
    logic [DW-1:0] rdata_q, rdata_d;
    logic [3:0] sync_dly_q, sync_dly_d;
    logic fb_sync_q, fb_sync_d;
    logic mod_on, first_start, second_start;

    // Byte lane of a spacing count; the top lane carries only a nibble.
    function automatic logic [DW-1:0] spacing_byte(input logic [SW-1:0] v,
                                                   input logic [1:0] lane);
        logic [DW-1:0] b;
        case (lane)
            2'h0: b = v[7:0];
            2'h1: b = v[15:8];
            2'h2: b = v[23:16];
            default: b = {{(DW-NW){1'b0}}, v[SW-1:24]}; // R12
        endcase
        return b;
    endfunction : spacing_byte

    function automatic logic [SW-1:0] spacing_write(input logic [SW-1:0] v,
                                                    input logic [1:0] lane,
                                                    input logic [DW-1:0] d);
        logic [SW-1:0] r;
        r = v;
        case (lane)
            2'h0: r[7:0] = d;
            2'h1: r[15:8] = d;
            2'h2: r[23:16] = d;
            default: r[SW-1:24] = d[NW-1:0]; // R03 R12
        endcase
        return r;
    endfunction : spacing_write

    always_comb begin
        step_d = step_q;
        spacing_a_d = spacing_a_q;
        spacing_b_d = spacing_b_q;
        sync_ofs_d = sync_ofs_q;
        mod_first_d = mod_first_q;
        if (reg_write) begin
            case (reg_addr)
                emb_mod_pkg::ADDR_STEP_LO: step_d[7:0] = reg_wdata; // R01
                emb_mod_pkg::ADDR_STEP_HI: step_d[15:8] = reg_wdata; // R01
                emb_mod_pkg::ADDR_SPACING_A0:
                    spacing_a_d = spacing_write(spacing_a_q, 2'h0, reg_wdata);
                emb_mod_pkg::ADDR_SPACING_A1:
                    spacing_a_d = spacing_write(spacing_a_q, 2'h1, reg_wdata);
                emb_mod_pkg::ADDR_SPACING_A2:
                    spacing_a_d = spacing_write(spacing_a_q, 2'h2, reg_wdata);
                emb_mod_pkg::ADDR_SPACING_A3:
                    spacing_a_d = spacing_write(spacing_a_q, 2'h3, reg_wdata);
                emb_mod_pkg::ADDR_SPACING_B0:
                    spacing_b_d = spacing_write(spacing_b_q, 2'h0, reg_wdata);
                emb_mod_pkg::ADDR_SPACING_B1:
                    spacing_b_d = spacing_write(spacing_b_q, 2'h1, reg_wdata);
                emb_mod_pkg::ADDR_SPACING_B2:
                    spacing_b_d = spacing_write(spacing_b_q, 2'h2, reg_wdata);
                emb_mod_pkg::ADDR_SPACING_B3:
                    spacing_b_d = spacing_write(spacing_b_q, 2'h3, reg_wdata);
                emb_mod_pkg::ADDR_SYNC_OFS: begin
                    sync_ofs_d = reg_wdata[emb_mod_pkg::SYNC_OFS_W-1:0]; // R05 R12
                end
                emb_mod_pkg::ADDR_MOD_FIRST: begin
                    mod_first_d = reg_wdata[emb_mod_pkg::SETTINGS_W-1:0]; // R12
                end
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        rdata_d = emb_mod_pkg::RESET_BYTE;
        if (reg_read) begin
            case (reg_addr)
                emb_mod_pkg::ADDR_STEP_LO: rdata_d = step_q[7:0];
                emb_mod_pkg::ADDR_STEP_HI: rdata_d = step_q[15:8];
                emb_mod_pkg::ADDR_SPACING_A0: rdata_d = spacing_byte(spacing_a_q, 2'h0);
                emb_mod_pkg::ADDR_SPACING_A1: rdata_d = spacing_byte(spacing_a_q, 2'h1);
                emb_mod_pkg::ADDR_SPACING_A2: rdata_d = spacing_byte(spacing_a_q, 2'h2);
                emb_mod_pkg::ADDR_SPACING_A3: rdata_d = spacing_byte(spacing_a_q, 2'h3);
                emb_mod_pkg::ADDR_SPACING_B0: rdata_d = spacing_byte(spacing_b_q, 2'h0);
                emb_mod_pkg::ADDR_SPACING_B1: rdata_d = spacing_byte(spacing_b_q, 2'h1);
                emb_mod_pkg::ADDR_SPACING_B2: rdata_d = spacing_byte(spacing_b_q, 2'h2);
                emb_mod_pkg::ADDR_SPACING_B3: rdata_d = spacing_byte(spacing_b_q, 2'h3);
                emb_mod_pkg::ADDR_SYNC_OFS: begin
                    rdata_d = {{(DW-emb_mod_pkg::SYNC_OFS_W){1'b0}}, sync_ofs_q}; // R12
                end
                emb_mod_pkg::ADDR_MOD_FIRST: begin
                    rdata_d = {{(DW-emb_mod_pkg::SETTINGS_W){1'b0}}, mod_first_q}; // R12
                end
                default: rdata_d = emb_mod_pkg::RESET_BYTE;
            endcase
        end
    end

    // The feedback sync edge is delayed only while some output modulates;
    // otherwise the base edge passes straight through.
    always_comb begin
        mod_on = mod_first_q[emb_mod_pkg::BIT_ENABLE] || second_modulator_enable;
        sync_dly_d = {sync_dly_q[2:0], fb_sync_base};
        if (!mod_on) begin
            fb_sync_d = fb_sync_base; // R06
        end else if (sync_ofs_q == 2'h0) begin
            fb_sync_d = fb_sync_base; // R05
        end else begin
            fb_sync_d = sync_dly_q[sync_ofs_q - 2'h1]; // R05
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            step_q <= '0;
            spacing_a_q <= '0;
            spacing_b_q <= '0;
            sync_ofs_q <= '0;
            mod_first_q <= '0;
            rdata_q <= emb_mod_pkg::RESET_BYTE;
            sync_dly_q <= 4'h0;
            fb_sync_q <= 1'b0;
        end else begin
            step_q <= step_d;
            spacing_a_q <= spacing_a_d;
            spacing_b_q <= spacing_b_d;
            sync_ofs_q <= sync_ofs_d;
            mod_first_q <= mod_first_d;
            rdata_q <= rdata_d;
            sync_dly_q <= sync_dly_d;
            fb_sync_q <= fb_sync_d;
        end
    end

    assign reg_rdata = rdata_q;
    assign fb_sync = fb_sync_q;

    mod_channel #(.SPACING_W(SW), .STEP_W(emb_mod_pkg::STEP_W)) u_first (
        .clk(clk),
        .rst(rst),
        .enable(mod_first_q[emb_mod_pkg::BIT_ENABLE]),
        .polarity(mod_first_q[emb_mod_pkg::BIT_POLARITY]),
        .single_pulse(mod_first_q[emb_mod_pkg::BIT_SINGLE]),
        .burst_enable(mod_first_q[emb_mod_pkg::BIT_BURST]),
        .burst_mode_level(burst_request_mode),
        .burst_req(burst_request),
        .div_tick(first_div_tick),
        .spacing(spacing_a_q),
        .step(step_q),
        .ev_active_q(first_event_active),
        .ev_high_q(first_event_high),
        .ev_start_q(first_start),
        .ev_shift_q(first_event_shift)
    );

    mod_channel #(.SPACING_W(SW), .STEP_W(emb_mod_pkg::STEP_W)) u_second (
        .clk(clk),
        .rst(rst),
        .enable(second_modulator_enable),
        .polarity(second_event_polarity),
        .single_pulse(second_single_pulse_select),
        .burst_enable(second_burst_enable),
        .burst_mode_level(burst_request_mode),
        .burst_req(burst_request),
        .div_tick(second_div_tick),
        .spacing(spacing_b_q),
        .step(step_q),
        .ev_active_q(second_event_active),
        .ev_high_q(second_event_high),
        .ev_start_q(second_start),
        .ev_shift_q(second_event_shift)
    );

    AST_STEP_HELD: assert property (@(posedge clk) disable iff (rst) // R01
        (reg_write && reg_addr == emb_mod_pkg::ADDR_STEP_HI) |=> step_q[15:8] == $past(reg_wdata))
        else $error("Step high byte not stored.");
    AST_SPACING_NIBBLE: assert property (@(posedge clk) disable iff (rst) // R03
        (reg_write && reg_addr == emb_mod_pkg::ADDR_SPACING_A3)
        |=> spacing_a_q[SW-1:24] == $past(reg_wdata[NW-1:0]))
        else $error("Spacing top nibble not stored.");
    AST_RESERVED_ZERO: assert property (@(posedge clk) disable iff (rst) // R12
        (reg_read && reg_addr == emb_mod_pkg::ADDR_SPACING_B3) |=> reg_rdata[DW-1:NW] == 4'h0)
        else $error("Reserved spacing bits read nonzero.");
    AST_SYNC_PASS: assert property (@(posedge clk) disable iff (rst) // R06
        (!mod_on && fb_sync_base) |=> fb_sync) else $error("Sync delayed while unmodulated.");
    AST_SYNC_OFS3: assert property (@(posedge clk) disable iff (rst) // R05
        (mod_on && sync_ofs_q == 2'h3 && !fb_sync_base) ##1 (mod_on && sync_ofs_q == 2'h3)[*3]
        |=> fb_sync == $past(fb_sync_base, 4)) else $error("Sync offset of three not applied.");
    COV_SYNC_DELAYED: cover property (@(posedge clk) disable iff (rst)
        mod_on && fb_sync_base && sync_ofs_q == 2'h2 ##3 fb_sync);
    COV_BOTH_EVENTS: cover property (@(posedge clk) disable iff (rst)
        first_start && second_start);
endmodule : emb_clock_modulator

//--- verif/div_partner.sv
// Output divider model: paces both channels and counts the events they make.
`timescale 1ns/100ps
module div_partner #(
    parameter int PERIOD_A = 3,
    parameter int PERIOD_B = 4
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic active_a,
    input wire logic active_b,
    output logic tick_a,
    output logic tick_b,
    output int events_a,
    output int events_b
);
    int cnt_a;
    int cnt_b;
    logic prev_a;
    logic prev_b;
    // The two periods differ so that a swapped tick input changes the measured spacing.
    assign tick_a = (cnt_a == PERIOD_A - 1);
    assign tick_b = (cnt_b == PERIOD_B - 1);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_a <= 0;
            cnt_b <= 0;
            prev_a <= 1'b0;
            prev_b <= 1'b0;
            events_a <= 0;
            events_b <= 0;
        end else begin
            cnt_a <= tick_a ? 0 : cnt_a + 1;
            cnt_b <= tick_b ? 0 : cnt_b + 1;
            prev_a <= active_a;
            prev_b <= active_b;
            events_a <= events_a + int'(active_a && !prev_a);
            events_b <= events_b + int'(active_b && !prev_b);
        end
    end
endmodule : div_partner

//--- verif/test_emb_clock_modulator.sv
// Self-checking testbench of the embedded clock duty modulator.
`timescale 1ns/100ps
module test_emb_clock_modulator;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [15:0] reg_addr = 16'h0000;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [7:0] reg_rdata;
    logic tick_a;
    logic tick_b;
    logic req = 1'b0;
    logic req_mode = 1'b0;
    logic sec_en = 1'b0;
    logic sec_pol = 1'b0;
    logic sec_single = 1'b0;
    logic sec_burst = 1'b0;
    logic fb_base = 1'b0;
    logic act_a;
    logic high_a;
    logic act_b;
    logic high_b;
    logic [15:0] shift_a;
    logic [15:0] shift_b;
    logic fb_sync;
    int events_a;
    int events_b;
    int mismatches = 0;
    int checks_done = 0;

    always #5 clk = ~clk;

    emb_clock_modulator uut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .first_div_tick(tick_a), .second_div_tick(tick_b), .burst_request(req),
        .burst_request_mode(req_mode), .second_modulator_enable(sec_en),
        .second_event_polarity(sec_pol), .second_single_pulse_select(sec_single),
        .second_burst_enable(sec_burst), .fb_sync_base(fb_base), .first_event_active(act_a),
        .first_event_high(high_a), .first_event_shift(shift_a), .second_event_active(act_b),
        .second_event_high(high_b), .second_event_shift(shift_b), .fb_sync(fb_sync));

    div_partner partner (.clk(clk), .rst(rst), .active_a(act_a), .active_b(act_b),
        .tick_a(tick_a), .tick_b(tick_b), .events_a(events_a), .events_b(events_b));

    task automatic final_report();
        $display("checks_done=%0d mismatches=%0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : final_report

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask : wr

    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd

    task automatic regs_scn();
        logic [15:0] addrs [13] = '{16'h14c0, 16'h14c1, 16'h14c2, 16'h14c3, 16'h14c4, 16'h14c5,
            16'h14c6, 16'h14c7, 16'h14c8, 16'h14c9, 16'h14ce, 16'h14cf, 16'h14ca};
        logic [7:0] masks [13] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'h0f, 8'hff, 8'hff,
            8'hff, 8'h0f, 8'h03, 8'h0f, 8'h00};
        logic [7:0] d;
        for (int i = 0; i < 13; i++) begin
            rd(addrs[i], d);
            chk("reg_reset", d, 8'h00);
            wr(addrs[i], 8'hff);
            rd(addrs[i], d);
            chk("reg_mask", d, masks[i]);
            wr(addrs[i], 8'h00);
        end
    endtask : regs_scn

    // Counts divider ticks until the chosen channel starts a new event.
    task automatic wait_rise(input bit sec, output int n);
        logic prev;
        prev = sec ? act_b : act_a;
        n = 0;
        for (int i = 0; i < 600; i++) begin
            n += int'(sec ? tick_b : tick_a);
            @(posedge clk);
            #1;
            if ((sec ? act_b : act_a) && !prev) begin
                return;
            end
            prev = sec ? act_b : act_a;
        end
        chk("event_start_timeout", 1'b1, 1'b0);
        final_report();
    endtask : wait_rise

    task automatic ev_scn(input bit sec, input logic pol, input logic single, input int sp);
        int n;
        logic inv;
        wait_rise(sec, n);
        wait_rise(sec, n);
        chk("ev_period", n, (single ? 1 : 2) + sp);
        chk("ev_high", sec ? high_b : high_a, pol);
        chk("ev_shift", sec ? shift_b : shift_a, 16'h1234);
        inv = 1'b0;
        for (int i = 0; i < 100 && (sec ? act_b : act_a); i++) begin
            inv |= ((sec ? high_b : high_a) !== pol);
            @(posedge clk);
            #1;
        end
        chk("ev_balanced", inv, !single);
        @(posedge clk);
    endtask : ev_scn

    task automatic count_scn(input string what, input int cycles, input int exp);
        int e;
        int eb;
        e = events_a;
        eb = events_b;
        repeat (cycles) @(posedge clk);
        chk(what, events_a - e, exp);
        chk({what, "_b"}, events_b - eb, exp);
    endtask : count_scn

    task automatic burst_scn();
        int e;
        int eb;
        wr(16'h14cf, 8'h0b);
        sec_en <= 1'b1;
        sec_burst <= 1'b1;
        count_scn("burst_no_request", 60, 0);
        req <= 1'b1;
        count_scn("burst_held", 300, 5);
        req <= 1'b0;
        @(posedge clk);
        req <= 1'b1;
        @(posedge clk);
        req <= 1'b0;
        count_scn("burst_pulse", 300, 5);
        req_mode <= 1'b1;
        count_scn("level_low", 60, 0);
        e = events_a;
        eb = events_b;
        req <= 1'b1;
        repeat (300) @(posedge clk);
        chk("level_high", (events_a - e) > 10, 1'b1);
        chk("level_high_b", (events_b - eb) > 10, 1'b1);
        req <= 1'b0;
        repeat (20) @(posedge clk);
        count_scn("level_dropped", 100, 0);
        wr(16'h14cf, 8'h00);
        sec_en <= 1'b0;
        repeat (20) @(posedge clk);
        count_scn("disabled", 100, 0);
    endtask : burst_scn

    task automatic fb_scn(input logic [7:0] set, input logic [1:0] ofs, input int exp);
        int n;
        wr(16'h14cf, set);
        wr(16'h14ce, {6'h00, ofs});
        @(posedge clk);
        fb_base <= 1'b1;
        @(posedge clk);
        fb_base <= 1'b0;
        #1;
        // The pulse seen right after the base edge counts as one cycle of delay.
        n = 1;
        while (fb_sync !== 1'b1 && n < 10) begin
            @(posedge clk);
            #1;
            n++;
        end
        chk("fb_delay", n, exp);
        @(posedge clk);
    endtask : fb_scn

    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        regs_scn();
        wr(16'h14c0, 8'h34);
        wr(16'h14c1, 8'h12);
        wr(16'h14c2, 8'h03);
        wr(16'h14c6, 8'h02);
        wr(16'h14cf, 8'h03);
        ev_scn(1'b0, 1'b1, 1'b0, 3);
        wr(16'h14cf, 8'h05);
        ev_scn(1'b0, 1'b0, 1'b1, 3);
        wr(16'h14cf, 8'h00);
        sec_en <= 1'b1;
        sec_pol <= 1'b1;
        ev_scn(1'b1, 1'b1, 1'b0, 2);
        sec_pol <= 1'b0;
        sec_single <= 1'b1;
        ev_scn(1'b1, 1'b0, 1'b1, 2);
        sec_en <= 1'b0;
        burst_scn();
        for (int k = 0; k < 4; k++) begin
            fb_scn(8'h01, k[1:0], 1 + k);
        end
        fb_scn(8'h00, 2'h3, 1);
        sec_en <= 1'b1;
        fb_scn(8'h00, 2'h2, 3);
        final_report();
    end
endmodule : test_emb_clock_modulator
